// File: lcd_ac_drive_timing.sv
// Notes on behaviour
// - Eight-colour mode keeps extremes, mid supply off
// - Eight-colour mode ignores both gamma trim sets
// - Reversal per field or every n rows
// - Rows per reversal equal field plus one
// - Interlace splits frame into three fields
// - Frame mode reverses after each field is drawn
// - Blank after reversal keeps every gate off
// - Interlace inserts blank between fields
// - Progressive row mode blanks only after whole screen
// - Porch lengths from two fields at 08h
// - Inter-field blanks from two fields at 09h
// - Frame rows equal lines plus porches
// - Interlace frame also counts both field blanks
//
// Register access over AHB-Lite and the register addresses are this design's own decisions.
`timescale 1ns/10ps
module lcd_ac_drive_timing import lcd_ac_pkg::*; #(
  parameter int ADDR_W = 8
) (
  // Clock, reset, enable
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [ADDR_W-1:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Panel drive
  output logic gate_on_o,
  output logic [7:0] gate_row_o,
  output logic polarity_o,
  output logic [1:0] field_o,
  output logic line_start_o,
  output logic eight_colour_o,
  output logic mid_supply_en_o,
  output logic [17:0] pos_trim_o,
  output logic [17:0] neg_trim_o
);

  logic [31:0] porch_q, blank_q, ctrl_q, timing_q;
  logic [17:0] ptrim_q, ntrim_q;
  logic wr_pend_q;
  logic [5:0] wr_idx_q;
  logic [31:0] rd_mux;
  logic [5:0] ap_idx;
  logic ap_valid;

  // Configuration fields
  logic [3:0] back_porch_lines, front_porch_lines, first_field_blank_lines;
  logic [3:0] second_field_blank_lines, blk_len;
  logic en, nrow_mode, eight, interlace;
  logic [5:0] rows_per_inversion_minus_one;
  logic [7:0] nl;
  logic [4:0] cpr_last;
  logic [3:0] div_last;

  assign back_porch_lines = porch_q[BACK_PORCH_LSB +: 4];
  assign front_porch_lines = porch_q[FRONT_PORCH_LSB +: 4];
  assign first_field_blank_lines = blank_q[FIRST_BLANK_LSB +: 4];
  assign second_field_blank_lines = blank_q[SECOND_BLANK_LSB +: 4];
  assign en = ctrl_q[EN_BIT];
  assign nrow_mode = ctrl_q[NROW_BIT];
  assign eight = ctrl_q[EIGHT_BIT];
  assign interlace = (ctrl_q[FIELD_SELECT_LSB +: 2] == FIELD_SELECT_INTERLACE);
  assign rows_per_inversion_minus_one = ctrl_q[ROWS_PER_INV_LSB +: 6];
  assign nl = timing_q[NL_LSB +: 8];
  assign cpr_last = RTN_BASE_CLOCKS + {1'b0, timing_q[RTN_LSB +: 4]} - 5'h01;
  assign div_last = (4'h1 << timing_q[DIV_LSB +: 2]) - 4'h1;

  // Bus slave: zero wait state, always OKAY
  assign ap_valid = hsel_i && htrans_i[1] && hready_i;
  assign ap_idx = haddr_i[7:2];

  seq_state_e state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] row_q, row_d;
  logic [1:0] field_q, field_d;
  logic [5:0] nrow_cnt_q, nrow_cnt_d;
  logic pol_flip, frame_wrap, tick;
  logic [3:0] pre_q;
  logic [4:0] clk_q;
  logic [8:0] next_row;

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (ap_idx)
      REG_PORCH_IDX: rd_mux = porch_q;
      REG_BLANK_IDX: rd_mux = blank_q;
      REG_CTRL_IDX: rd_mux = ctrl_q;
      REG_TIMING_IDX: rd_mux = timing_q;
      REG_PTRIM_IDX: rd_mux = {14'h0000, ptrim_q};
      REG_NTRIM_IDX: rd_mux = {14'h0000, ntrim_q};
      REG_STATUS_IDX: begin
        rd_mux[ST_POL_BIT] = polarity_o;
        rd_mux[ST_GATE_BIT] = gate_on_o;
        rd_mux[ST_FIELD_LSB +: 2] = field_q;
        rd_mux[ST_ROW_LSB +: 8] = row_q;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      wr_pend_q <= 1'b0;
      wr_idx_q <= 6'h00;
      hrdata_o <= 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end else if (ce_i) begin
      wr_pend_q <= ap_valid && hwrite_i;
      wr_idx_q <= ap_idx;
      if (ap_valid && !hwrite_i) begin
        hrdata_o <= rd_mux;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      porch_q <= PORCH_RST;
      blank_q <= BLANK_RST;
      ctrl_q <= CTRL_RST;
      timing_q <= TIMING_RST;
      ptrim_q <= TRIM_RST;
      ntrim_q <= TRIM_RST;
    end else if (ce_i && wr_pend_q) begin
      unique case (wr_idx_q)
        REG_PORCH_IDX: porch_q <= {20'h00000, hwdata_i[11:8], 4'h0, hwdata_i[3:0]};
        REG_BLANK_IDX: blank_q <= {20'h00000, hwdata_i[11:8], 4'h0, hwdata_i[3:0]};
        REG_CTRL_IDX: ctrl_q <= {18'h00000, hwdata_i[13:8], 2'h0, hwdata_i[5:4], 1'b0,
                                 hwdata_i[2:0]};
        REG_TIMING_IDX: timing_q <= {18'h00000, hwdata_i[13:0]};
        REG_PTRIM_IDX: ptrim_q <= hwdata_i[17:0];
        REG_NTRIM_IDX: ntrim_q <= hwdata_i[17:0];
        default: ;
      endcase
    end
  end

  // Row clock: (16 + rtn) clocks per row, each clock divided by 2^div
  assign tick = en && (pre_q == div_last) && (clk_q == cpr_last);

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      pre_q <= 4'h0;
      clk_q <= 5'h00;
    end else if (ce_i) begin
      if (!en) begin
        pre_q <= 4'h0;
        clk_q <= 5'h00;
      end else if (pre_q == div_last) begin
        pre_q <= 4'h0;
        clk_q <= (clk_q == cpr_last) ? 5'h00 : clk_q + 5'h01;
      end else begin
        pre_q <= pre_q + 4'h1;
      end
    end
  end

  assign next_row = {1'b0, row_q} + (interlace ? INTERLACE_STEP : PROGRESSIVE_STEP);
  assign blk_len = (field_q == 2'h1) ? first_field_blank_lines : second_field_blank_lines;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    row_d = row_q;
    field_d = field_q;
    nrow_cnt_d = nrow_cnt_q;
    pol_flip = 1'b0;
    frame_wrap = 1'b0;
    if (!en) begin
      state_d = ST_IDLE;
      cnt_d = 4'h0;
      row_d = 8'h00;
      field_d = 2'h0;
      nrow_cnt_d = 6'h00;
    end else if (tick) begin
      unique case (state_q)
        ST_IDLE: begin
          cnt_d = 4'h0;
          state_d = (back_porch_lines != 4'h0) ? ST_BACK : ST_ACT;
        end
        ST_BACK: begin
          cnt_d = cnt_q + 4'h1;
          if (cnt_q + 4'h1 == back_porch_lines) begin
            state_d = ST_ACT;
            cnt_d = 4'h0;
          end
        end
        ST_ACT: begin
          if (nrow_mode) begin
            if (nrow_cnt_q == rows_per_inversion_minus_one) begin
              pol_flip = 1'b1;
              nrow_cnt_d = 6'h00;
            end else begin
              nrow_cnt_d = nrow_cnt_q + 6'h01;
            end
          end
          if (next_row >= {1'b0, nl}) begin
            if (!nrow_mode) begin
              pol_flip = 1'b1;
            end
            if (interlace && field_q != LAST_FIELD) begin
              field_d = field_q + 2'h1;
              row_d = {6'h00, field_d};
              cnt_d = 4'h0;
              state_d = ((field_q == 2'h0 ? first_field_blank_lines : second_field_blank_lines)
                         != 4'h0) ? ST_BLK : ST_ACT;
            end else begin
              frame_wrap = 1'b1;
              nrow_cnt_d = 6'h00;
              field_d = 2'h0;
              row_d = 8'h00;
              cnt_d = 4'h0;
              state_d = (front_porch_lines != 4'h0) ? ST_FRONT
                      : (back_porch_lines != 4'h0) ? ST_BACK : ST_ACT;
            end
          end else begin
            row_d = next_row[7:0];
          end
        end
        ST_BLK: begin
          cnt_d = cnt_q + 4'h1;
          if (cnt_q + 4'h1 == blk_len) begin
            state_d = ST_ACT;
            cnt_d = 4'h0;
          end
        end
        ST_FRONT: begin
          cnt_d = cnt_q + 4'h1;
          if (cnt_q + 4'h1 == front_porch_lines) begin
            state_d = (back_porch_lines != 4'h0) ? ST_BACK : ST_ACT;
            cnt_d = 4'h0;
          end
        end
        default: state_d = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
      row_q <= 8'h00;
      field_q <= 2'h0;
      nrow_cnt_q <= 6'h00;
    end else if (ce_i) begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      row_q <= row_d;
      field_q <= field_d;
      nrow_cnt_q <= nrow_cnt_d;
    end
  end

  // Panel outputs
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      gate_on_o <= 1'b0;
      gate_row_o <= 8'h00;
      polarity_o <= 1'b0;
      field_o <= 2'h0;
      line_start_o <= 1'b0;
    end else if (ce_i) begin
      gate_on_o <= (state_d == ST_ACT);
      gate_row_o <= row_d;
      field_o <= field_d;
      line_start_o <= tick;
      if (pol_flip) begin
        polarity_o <= !polarity_o;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      eight_colour_o <= 1'b0;
      mid_supply_en_o <= 1'b1;
      pos_trim_o <= TRIM_RST;
      neg_trim_o <= TRIM_RST;
    end else if (ce_i) begin
      eight_colour_o <= eight;
      mid_supply_en_o <= !eight;
      pos_trim_o <= eight ? TRIM_RST : ptrim_q;
      neg_trim_o <= eight ? TRIM_RST : ntrim_q;
    end
  end

  // Frame length checker
  logic [9:0] rows_seen_q, frame_rows;
  logic frame_seen_q;
  assign frame_rows = {2'h0, nl} + {6'h00, back_porch_lines} + {6'h00, front_porch_lines}
      + (interlace ? {6'h00, first_field_blank_lines} + {6'h00, second_field_blank_lines}
      : 10'h000);
  always_ff @(posedge mclk_i) begin
    if (reset_i || (ce_i && !en)) begin
      rows_seen_q <= 10'h000;
      frame_seen_q <= 1'b0;
    end else if (ce_i && tick) begin
      rows_seen_q <= frame_wrap ? 10'h000 : rows_seen_q + 10'h001;
      frame_seen_q <= frame_seen_q || frame_wrap;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  sequence row_end_s;
    ce_i && tick && state_q == ST_ACT && next_row >= {1'b0, nl};
  endsequence

  sequence frame_end_s;
    row_end_s ##0 !(interlace && field_q != LAST_FIELD);
  endsequence

  eight_supply_a: assert property ((ce_i && eight) |=> !mid_supply_en_o && eight_colour_o)
    else $error("mid grayscale supply on in eight-colour mode");
  trim_off_a: assert property ((ce_i && eight)
      |=> pos_trim_o == TRIM_RST && neg_trim_o == TRIM_RST)
    else $error("gamma trim passed in eight-colour mode");
  nrow_flip_a: assert property ((ce_i && tick && state_q == ST_ACT && nrow_mode
      && nrow_cnt_q == rows_per_inversion_minus_one) |=> polarity_o != $past(polarity_o))
    else $error("row group reversal missed");
  nrow_hold_a: assert property ((ce_i && tick && state_q == ST_ACT && nrow_mode
      && nrow_cnt_q != rows_per_inversion_minus_one) |=> polarity_o == $past(polarity_o))
    else $error("polarity changed inside row group");
  frame_flip_a: assert property ((row_end_s ##0 !nrow_mode) |=> $changed(polarity_o))
    else $error("frame reversal missed");
  gate_blank_a: assert property (gate_on_o |-> state_q == ST_ACT)
    else $error("gate on outside active rows");
  field_blank_a: assert property ((row_end_s ##0 interlace && field_q == 2'h0
      && first_field_blank_lines != 4'h0)
      |=> state_q == ST_BLK && field_q == 2'h1 && !gate_on_o)
    else $error("no blank between fields");
  nrow_noblank_a: assert property ((ce_i && tick && state_q == ST_ACT && !interlace
      && next_row < {1'b0, nl}) |=> state_q == ST_ACT && gate_row_o == $past(row_q) + 8'h01)
    else $error("blank inside screen drawing");
  frame_len_a: assert property ((frame_end_s ##0 frame_seen_q)
      |-> rows_seen_q + 10'h001 == frame_rows)
    else $error("frame row count wrong");
  porch_front_a: assert property ((frame_end_s ##0 front_porch_lines != 4'h0)
      |=> state_q == ST_FRONT && cnt_q == 4'h0)
    else $error("front porch not entered");

endmodule // lcd_ac_drive_timing

// File: lcd_ac_pkg.sv
package lcd_ac_pkg;
  // Register indices; byte address is four times the index
  localparam logic [5:0] REG_PORCH_IDX = 6'h08;
  localparam logic [5:0] REG_BLANK_IDX = 6'h09;
  localparam logic [5:0] REG_CTRL_IDX = 6'h10;
  localparam logic [5:0] REG_TIMING_IDX = 6'h11;
  localparam logic [5:0] REG_PTRIM_IDX = 6'h12;
  localparam logic [5:0] REG_NTRIM_IDX = 6'h13;
  localparam logic [5:0] REG_STATUS_IDX = 6'h14;
  // Porch register fields
  localparam int BACK_PORCH_LSB = 0;
  localparam int FRONT_PORCH_LSB = 8;
  // Inter-field blank register fields
  localparam int FIRST_BLANK_LSB = 0;
  localparam int SECOND_BLANK_LSB = 8;
  // Control register fields
  localparam int EN_BIT = 0;
  localparam int NROW_BIT = 1;
  localparam int EIGHT_BIT = 2;
  localparam int FIELD_SELECT_LSB = 4;
  localparam int ROWS_PER_INV_LSB = 8;
  // Timing register fields
  localparam int NL_LSB = 0;
  localparam int RTN_LSB = 8;
  localparam int DIV_LSB = 12;
  // Status register fields
  localparam int ST_POL_BIT = 0;
  localparam int ST_GATE_BIT = 1;
  localparam int ST_FIELD_LSB = 2;
  localparam int ST_ROW_LSB = 8;
  // Reset values
  localparam logic [31:0] PORCH_RST = 32'h0000_0404;
  localparam logic [31:0] BLANK_RST = 32'h0000_0000;
  localparam logic [31:0] CTRL_RST = 32'h0000_0010;
  localparam logic [31:0] TIMING_RST = 32'h0000_00B0;
  localparam logic [17:0] TRIM_RST = 18'h0_0000;
  // Timing
  localparam logic [4:0] RTN_BASE_CLOCKS = 5'h10;
  localparam logic [1:0] FIELD_SELECT_INTERLACE = 2'h3;
  localparam logic [1:0] LAST_FIELD = 2'h2;
  localparam logic [8:0] INTERLACE_STEP = 9'h003;
  localparam logic [8:0] PROGRESSIVE_STEP = 9'h001;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_BACK = 5'b00010,
    ST_ACT = 5'b00100,
    ST_BLK = 5'b01000,
    ST_FRONT = 5'b10000
  } seq_state_e;
endpackage

// File: lcd_panel_model.sv
`timescale 1ns/10ps
module lcd_panel_model (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // Panel drive lines
  input wire logic gate_on_i,
  input wire logic [7:0] gate_row_i,
  input wire logic polarity_i,
  input wire logic [1:0] field_i,
  input wire logic line_start_i,
  // Measurements of the last whole frame
  output logic [15:0] frame_cycles_o,
  output logic [7:0] toggles_o,
  output logic [7:0] rows_o,
  output logic [7:0] frames_o
);
  logic gate_q;
  logic pol_q;
  logic [15:0] cyc_q;
  logic [7:0] tog_q;
  logic [7:0] row_q;
  logic start;
  // A frame opens when row 0 of field 0 is first driven
  assign start = gate_on_i && !gate_q && gate_row_i == 8'h00 && field_i == 2'h0;
  always_ff @(posedge mclk_i) begin
    gate_q <= gate_on_i;
    pol_q <= polarity_i;
    if (reset_i) begin
      {cyc_q, tog_q, row_q, frame_cycles_o, toggles_o, rows_o, frames_o} <= '0;
    end else if (start) begin
      frame_cycles_o <= cyc_q;
      toggles_o <= tog_q;
      rows_o <= row_q;
      frames_o <= frames_o + 8'h01;
      cyc_q <= 16'h0001;
      // The opening row is drawn at this edge and belongs to the new frame
      tog_q <= 8'(polarity_i != pol_q);
      row_q <= 8'(line_start_i);
    end else begin
      cyc_q <= cyc_q + 16'h0001;
      tog_q <= tog_q + 8'(polarity_i != pol_q);
      // Only rows driven with the gate on count as drawn
      row_q <= row_q + 8'(line_start_i && gate_on_i);
    end
  end
endmodule // lcd_panel_model

// File: lcd_ac_drive_timing_test.sv
`timescale 1ns/10ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin bad_count++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, e); end end
module lcd_ac_drive_timing_test import lcd_ac_pkg::*;;
  logic mclk_i = 0, reset_i = 1, hsel_i = 0, hwrite_i = 0, ce_i = 1;
  logic [7:0] haddr_i = '0;
  logic [1:0] htrans_i = '0;
  logic [31:0] hwdata_i = '0, hrdata_o, rd;
  logic hreadyout_o, hresp_o, gate_on_o, polarity_o, line_start_o, eight_colour_o;
  logic mid_supply_en_o;
  logic [7:0] gate_row_o, toggles, rows, frames;
  logic [1:0] field_o;
  logic [17:0] pos_trim_o, neg_trim_o;
  logic [15:0] cycles;
  int bad_count = 0, n_compared = 0, ticks = 0;
  typedef struct {logic [31:0] ctrl, timing, porch, blank; logic [15:0] cyc;
    logic [7:0] tog, rows;} case_s;
  case_s cases [5] = '{
    '{32'h11, 32'h002, 32'h0101, 32'h0, 16'd64, 8'd1, 8'd2},
    '{32'h11, 32'h1202, 32'h0302, 32'h0, 16'd252, 8'd1, 8'd2},
    '{32'h0113, 32'h005, 32'h0101, 32'h0, 16'd112, 8'd2, 8'd5},
    '{32'h0013, 32'h003, 32'h0101, 32'h0, 16'd80, 8'd3, 8'd3},
    '{32'h31, 32'h006, 32'h0101, 32'h0201, 16'd176, 8'd3, 8'd6}};
  initial begin
    forever #2 mclk_i = ~mclk_i;
  end
  lcd_ac_drive_timing i_dut (.mclk_i(mclk_i), .reset_i(reset_i), .ce_i(ce_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2),
    .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .gate_on_o(gate_on_o),
    .gate_row_o(gate_row_o), .polarity_o(polarity_o), .field_o(field_o),
    .line_start_o(line_start_o), .eight_colour_o(eight_colour_o),
    .mid_supply_en_o(mid_supply_en_o), .pos_trim_o(pos_trim_o), .neg_trim_o(neg_trim_o));
  lcd_panel_model i_panel (.mclk_i(mclk_i), .reset_i(reset_i), .gate_on_i(gate_on_o),
    .gate_row_i(gate_row_o), .polarity_i(polarity_o), .field_i(field_o),
    .line_start_i(line_start_o), .frame_cycles_o(cycles), .toggles_o(toggles),
    .rows_o(rows), .frames_o(frames));
  task automatic bus(input logic [5:0] idx, input logic wr, input logic [31:0] d);
    htrans_i <= 2'h2;
    hsel_i <= 1'b1;
    haddr_i <= {idx, 2'b00};
    hwrite_i <= wr;
    @(posedge mclk_i);
    while (hreadyout_o !== 1'b1) @(posedge mclk_i);
    htrans_i <= 2'h0;
    hwdata_i <= d;
    @(posedge mclk_i);
    while (hreadyout_o !== 1'b1) @(posedge mclk_i);
    rd = hrdata_o;
    `CHK(hresp_o, 1'b0)
  endtask
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge mclk_i) begin
    ticks++;
    if (ticks == 40000) begin
      bad_count++;
      conclude();
    end
  end
  initial begin
    logic [7:0] f0;
    repeat (16) @(posedge mclk_i);
    reset_i <= 1'b0;
    @(posedge mclk_i);
    foreach (cases[i]) begin
      bus(REG_CTRL_IDX, 1'b1, 32'h0);
      bus(REG_PORCH_IDX, 1'b1, cases[i].porch);
      bus(REG_BLANK_IDX, 1'b1, cases[i].blank);
      bus(REG_TIMING_IDX, 1'b1, cases[i].timing);
      // Rows per reversal chosen per case as a host would after a panel check
      bus(REG_CTRL_IDX, 1'b1, cases[i].ctrl);
      f0 = frames;
      while (frames != f0 + 8'd3) @(posedge mclk_i);
      `CHK(cycles, cases[i].cyc)
      `CHK(toggles, cases[i].tog)
      `CHK(rows, cases[i].rows)
    end
    reset_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    reset_i <= 1'b0;
    @(posedge mclk_i);
    `CHK({gate_on_o, polarity_o, mid_supply_en_o, field_o}, 5'b00100)
    bus(REG_PORCH_IDX, 1'b0, 32'h0);
    `CHK(rd, PORCH_RST)
    bus(REG_BLANK_IDX, 1'b0, 32'h0);
    `CHK(rd, BLANK_RST)
    bus(REG_CTRL_IDX, 1'b0, 32'h0);
    `CHK(rd, CTRL_RST)
    bus(REG_TIMING_IDX, 1'b0, 32'h0);
    `CHK(rd, TIMING_RST)
    bus(6'h0F, 1'b1, 32'hFFFF_FFFF);
    bus(6'h0F, 1'b0, 32'h0);
    `CHK(rd, 32'h0)
    bus(REG_STATUS_IDX, 1'b1, 32'hFFFF_FFFF);
    bus(REG_STATUS_IDX, 1'b0, 32'h0);
    `CHK(rd, 32'h0)
    // Graphics memory assumed loaded with extreme values before the switch
    bus(REG_PTRIM_IDX, 1'b1, 32'h0002_AAAA);
    bus(REG_NTRIM_IDX, 1'b1, 32'h0001_5555);
    bus(REG_CTRL_IDX, 1'b1, 32'h15);
    repeat (3) @(posedge mclk_i);
    `CHK({eight_colour_o, mid_supply_en_o}, 2'b10)
    `CHK({pos_trim_o, neg_trim_o}, 36'h0)
    bus(REG_CTRL_IDX, 1'b1, 32'h11);
    repeat (3) @(posedge mclk_i);
    `CHK({eight_colour_o, mid_supply_en_o}, 2'b01)
    `CHK({pos_trim_o, neg_trim_o}, {18'h2AAAA, 18'h15555})
    bus(REG_PTRIM_IDX, 1'b0, 32'h0);
    `CHK(rd, 32'h0002_AAAA)
    // Nothing is taken while the clock enable is low
    ce_i <= 1'b0;
    bus(REG_PTRIM_IDX, 1'b1, 32'h0000_1234);
    ce_i <= 1'b1;
    bus(REG_PTRIM_IDX, 1'b0, 32'h0);
    `CHK(rd, 32'h0002_AAAA)
    conclude();
  end
endmodule // lcd_ac_drive_timing_test
